/* src/bih_top.sv */
// board interrupt handler: backplane, on-board and interprocessor requests
//
// Design decision made here: the AXI4-Lite slave port.
`include "bih_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Each of the seven backplane request levels is taken only if its jumper enables it.
// - The serial port request reaches the processor at level 5.
// - The 60 Hz tick reaches the processor at level 6.
// - Power failure or memory parity error raises the non-maskable interrupt.
// - A backplane access to this board's interprocessor address forces level 4 or 7 by jumper.
// - The processor acknowledge of that interprocessor interrupt is answered with autovector.
// - A vectored interprocessor interrupt drives one backplane request line of levels 3 to 6.
// - Its backplane acknowledge is answered with the 8-bit vector register on the data bus.
// - The vector register is software writable at 5c000000 in on-board I/O space.
module bih_top #(
	parameter int unsigned TICK_CYCLES = `BIH_TICK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register bus, write
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus, read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// configuration jumpers
	input wire logic [7:1] jmp_level_en,
	input wire logic jmp_ipi_level7,
	input wire logic [31:0] jmp_ipi_addr,
	// on-board sources
	input wire logic serial_port_irq_n,
	input wire logic power_fail_n,
	input wire logic parity_err_n,
	// backplane requests and accesses
	input wire logic [7:1] bp_irq_n,
	input wire logic bp_as_n,
	input wire logic [31:0] bp_addr,
	// backplane request drive, open drain, levels 6..3
	output logic [6:3] bp_irq_out,
	output logic [6:3] bp_irq_oe,
	// backplane acknowledge
	input wire logic bp_iack_n,
	input wire logic bp_iackin_n,
	input wire logic [2:0] bp_iack_lvl,
	output logic bp_iackout_n,
	output logic [7:0] bp_data_out,
	output logic bp_data_oe,
	output logic bp_dtack_n,
	// processor side
	output logic [2:0] cpu_ipl,
	output logic nonmaskable_irq,
	input wire logic cpu_iack,
	input wire logic [2:0] cpu_iack_lvl,
	output logic cpu_avec,
	// interrupt to software
	output logic irq
);

	bih_pkg::bih_state_s s_q;
	bih_pkg::bih_state_s s_d;
	logic tick;
	logic [7:1] req;
	logic nmi_now;
	logic ipi_hit;
	logic [2:0] ipi_lvl;
	logic [3:0] set_ev;
	logic aw_now;
	logic w_now;
	logic [31:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic rd_hit;
	logic [31:0] rd_val;
	logic rd_status;
	logic [3:0] vclr;
	logic our_iack;

	// highest requesting level, zero when none
	function automatic logic [2:0] prio(input logic [7:1] r);
		logic [2:0] p;
		p = 3'h0;
		for (int i = 1; i <= 7; i++)
		begin
			if (r[i])
				p = 3'(i);
		end
		return p;
	endfunction : prio

	bih_tick_div #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.srst(srst),
		.tick(tick)
	);

	always_comb
	begin
		s_d = s_q;
		set_ev = 4'h0;
		vclr = 4'h0;

		nmi_now = ~power_fail_n | ~parity_err_n;
		s_d.nmi_out = nmi_now;
		s_d.nmi_prev = nmi_now;
		if (nmi_now && !s_q.nmi_prev)
			set_ev[`BIH_ST_NMI] = 1'b1;

		if (tick)
		begin
			s_d.tick_pend = 1'b1;
			set_ev[`BIH_ST_TICK] = 1'b1;
		end

		// address match forces a local request
		ipi_lvl = jmp_ipi_level7 ? `BIH_IPI_LEVEL_HI : `BIH_IPI_LEVEL_LO;
		s_d.as_prev = ~bp_as_n;
		ipi_hit = ~bp_as_n & ~s_q.as_prev & (bp_addr == jmp_ipi_addr);
		if (ipi_hit)
		begin
			s_d.ipi_pend = 1'b1;
			set_ev[`BIH_ST_IPI] = 1'b1;
		end

		s_d.avec = 1'b0;
		s_d.avec_ipi = 1'b0;
		s_d.avec_tick = 1'b0;
		if (cpu_iack)
		begin
			if (s_q.ipi_pend && cpu_iack_lvl == ipi_lvl)
				s_d.avec_ipi = 1'b1;
			else if (s_q.tick_pend && cpu_iack_lvl == `BIH_TICK_LEVEL)
				s_d.avec_tick = 1'b1;
			s_d.avec = s_d.avec_ipi | s_d.avec_tick;
		end
		else
		begin
			// acknowledge over: source is serviced, new events still win
			if (s_q.avec_ipi && !ipi_hit)
				s_d.ipi_pend = 1'b0;
			if (s_q.avec_tick && !tick)
				s_d.tick_pend = 1'b0;
		end

		req = ~bp_irq_n & jmp_level_en;
		req[`BIH_SERIAL_LEVEL] = req[`BIH_SERIAL_LEVEL] | ~serial_port_irq_n;
		req[`BIH_TICK_LEVEL] = req[`BIH_TICK_LEVEL] | s_d.tick_pend;
		req[ipi_lvl] = req[ipi_lvl] | s_d.ipi_pend;
		req[7] = req[7] | nmi_now;
		s_d.ipl = prio(req);

		// answer the backplane acknowledge with the vector
		our_iack = ~bp_iack_n & ~bp_iackin_n & (s_q.vstate == bih_pkg::VS_PEND)
			& (bp_iack_lvl == s_q.ctrl_lvl);
		s_d.bp_iackout_n = ~(~bp_iack_n & ~bp_iackin_n & ~our_iack
			& (s_q.vstate != bih_pkg::VS_ANSWER));
		unique case (s_q.vstate)
			bih_pkg::VS_IDLE:
			begin
				s_d.irq_oe = 4'h0;
			end
			bih_pkg::VS_PEND:
			begin
				if (our_iack)
				begin
					s_d.bp_data = s_q.vector;
					s_d.bp_data_oe = 1'b1;
					s_d.bp_dtack_n = 1'b0;
					s_d.vstate = bih_pkg::VS_ANSWER;
				end
			end
			bih_pkg::VS_ANSWER:
			begin
				// drop the request when the cycle ends
				if (bp_iack_n)
				begin
					s_d.bp_data_oe = 1'b0;
					s_d.bp_dtack_n = 1'b1;
					s_d.irq_oe = 4'h0;
					s_d.vstate = bih_pkg::VS_IDLE;
					set_ev[`BIH_ST_VSENT] = 1'b1;
				end
			end
		endcase

		// write channel, address and data in either order
		aw_now = s_axi_awvalid & s_q.awready;
		w_now = s_axi_wvalid & s_q.wready;
		if (aw_now)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (w_now)
		begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		wa = aw_now ? s_axi_awaddr : s_q.aw_addr;
		wd = w_now ? s_axi_wdata : s_q.w_data;
		ws = w_now ? s_axi_wstrb : s_q.w_strb;
		if (s_d.aw_have && s_d.w_have && !s_q.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `BIH_RESP_OKAY;
			unique case (wa)
				`BIH_VECTOR_ADDR:
				begin
					if (ws[0])
						s_d.vector = wd[7:0];
				end
				`BIH_MASK_ADDR:
				begin
					if (ws[0])
						s_d.mask = wd[`BIH_ST_WIDTH-1:0];
				end
				`BIH_CTRL_ADDR:
				begin
					if (ws[0] && s_q.vstate == bih_pkg::VS_IDLE)
						s_d.ctrl_lvl = wd[`BIH_CTRL_LVL_MSB:`BIH_CTRL_LVL_LSB];
					// raise one of levels 3..6 on the backplane
					if (ws[1] && wd[`BIH_CTRL_GO] && s_q.vstate == bih_pkg::VS_IDLE
						&& s_d.ctrl_lvl >= `BIH_VLEVEL_MIN
						&& s_d.ctrl_lvl <= `BIH_VLEVEL_MAX)
					begin
						s_d.vstate = bih_pkg::VS_PEND;
						s_d.irq_oe = 4'h1 << (s_d.ctrl_lvl - `BIH_VLEVEL_MIN);
					end
				end
				`BIH_STATUS_ADDR, `BIH_STATE_ADDR:
				begin
				end
				default:
				begin
					s_d.bresp = `BIH_RESP_DECERR;
				end
			endcase
		end
		else if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end
		// one write in flight: hold ready low until the answer is taken
		s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
		s_d.wready = ~s_d.w_have & ~s_d.bvalid;

		// read channel, answer one cycle after the address
		rd_hit = 1'b1;
		rd_status = 1'b0;
		unique case (s_axi_araddr)
			`BIH_VECTOR_ADDR: rd_val = {24'h00_0000, s_q.vector};
			`BIH_STATUS_ADDR:
			begin
				rd_val = {28'h000_0000, s_q.status};
				rd_status = 1'b1;
			end
			`BIH_MASK_ADDR: rd_val = {28'h000_0000, s_q.mask};
			`BIH_CTRL_ADDR: rd_val = {29'h000_0000, s_q.ctrl_lvl};
			`BIH_STATE_ADDR:
				rd_val = {20'h0_0000, s_q.ipl, 1'b0, s_q.irq_oe,
					s_q.ipi_pend, s_q.tick_pend, s_q.vstate};
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val;
			s_d.rresp = rd_hit ? `BIH_RESP_OKAY : `BIH_RESP_DECERR;
			// read of status clears what it returned
			if (rd_status)
				vclr = s_q.status;
		end
		else if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = ~s_d.rvalid;

		// sticky events, a new event beats the clear
		s_d.status = (s_q.status & ~vclr) | set_ev;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s_q <= '0;
			s_q.vector <= `BIH_VECTOR_RST;
			s_q.mask <= `BIH_MASK_RST;
			s_q.ctrl_lvl <= `BIH_CTRL_LVL_RST;
			s_q.vstate <= bih_pkg::VS_IDLE;
			s_q.bp_dtack_n <= 1'b1;
			s_q.bp_iackout_n <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	// open drain: value is always low, only the enable moves
	assign bp_irq_out = 4'h0 & s_q.irq_oe;
	assign bp_irq_oe = s_q.irq_oe;
	assign bp_iackout_n = s_q.bp_iackout_n;
	assign bp_data_out = s_q.bp_data;
	assign bp_data_oe = s_q.bp_data_oe;
	assign bp_dtack_n = s_q.bp_dtack_n;
	assign cpu_ipl = s_q.ipl;
	assign nonmaskable_irq = s_q.nmi_out;
	assign cpu_avec = s_q.avec;
	assign irq = s_q.irq;

endmodule : bih_top

`default_nettype wire

/* src/bih_regs.svh */
// register map, field positions, reset values and timing of the handler
`ifndef BIH_REGS_SVH
`define BIH_REGS_SVH

// byte addresses on the register bus
`define BIH_VECTOR_ADDR 32'h5c00_0000
`define BIH_STATUS_ADDR 32'h5c00_0004
`define BIH_MASK_ADDR 32'h5c00_0008
`define BIH_CTRL_ADDR 32'h5c00_000c
`define BIH_STATE_ADDR 32'h5c00_0010

// status and mask bit positions
`define BIH_ST_NMI 0
`define BIH_ST_TICK 1
`define BIH_ST_IPI 2
`define BIH_ST_VSENT 3
`define BIH_ST_WIDTH 4

// control fields
`define BIH_CTRL_LVL_LSB 0
`define BIH_CTRL_LVL_MSB 2
`define BIH_CTRL_GO 8

// reset values
`define BIH_VECTOR_RST 8'h0f
`define BIH_MASK_RST 4'h0
`define BIH_CTRL_LVL_RST 3'h3

// processor levels of the on-board sources, and the backplane levels of the vectored request
`define BIH_SERIAL_LEVEL 3'h5
`define BIH_TICK_LEVEL 3'h6
`define BIH_IPI_LEVEL_LO 3'h4
`define BIH_IPI_LEVEL_HI 3'h7
`define BIH_VLEVEL_MIN 3'h3
`define BIH_VLEVEL_MAX 3'h6

// timing
`define BIH_CLK_HZ 20000000
`define BIH_TICK_HZ 60
`define BIH_TICK_CYCLES (`BIH_CLK_HZ / `BIH_TICK_HZ)

// bus answers
`define BIH_RESP_OKAY 2'h0
`define BIH_RESP_DECERR 2'h3

`endif

/* src/bih_pkg.sv */
// types shared by the interrupt handler modules
package bih_pkg;

	typedef enum logic [1:0] {
		VS_IDLE,
		VS_PEND,
		VS_ANSWER
	} bih_vstate_e;

	typedef struct packed {
		logic aw_have;
		logic [31:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] vector;
		logic [2:0] ctrl_lvl;
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		bih_vstate_e vstate;
		logic tick_pend;
		logic ipi_pend;
		logic nmi_prev;
		logic nmi_out;
		logic as_prev;
		logic [2:0] ipl;
		logic avec;
		logic avec_ipi;
		logic avec_tick;
		logic [3:0] irq_oe;
		logic [7:0] bp_data;
		logic bp_data_oe;
		logic bp_dtack_n;
		logic bp_iackout_n;
	} bih_state_s;

	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} bih_div_s;

endpackage : bih_pkg

/* src/bih_tick_div.sv */
// divider that yields a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/100ps
`default_nettype none

module bih_tick_div #(
	parameter int unsigned CYCLES = 333333
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// pulse out
	output logic tick
);

	bih_pkg::bih_div_s s_q;
	bih_pkg::bih_div_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.count >= 32'(CYCLES - 1))
		begin
			s_d.count = 32'h0000_0000;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.count = s_q.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;

endmodule : bih_tick_div

`default_nettype wire

/* sim/bih_top_chk.sv */
// port checker of the board interrupt handler
`timescale 1ns/100ps
`default_nettype none
module bih_chk (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// inputs
	input wire logic jmp_ipi_level7,
	input wire logic [31:0] jmp_ipi_addr,
	input wire logic power_fail_n,
	input wire logic parity_err_n,
	input wire logic bp_as_n,
	input wire logic [31:0] bp_addr,
	input wire logic bp_iack_n,
	input wire logic bp_iackin_n,
	input wire logic [2:0] bp_iack_lvl,
	input wire logic cpu_iack,
	input wire logic [2:0] cpu_iack_lvl,
	// outputs
	input wire logic [6:3] bp_irq_out,
	input wire logic [6:3] bp_irq_oe,
	input wire logic bp_data_oe,
	input wire logic bp_dtack_n,
	input wire logic bp_iackout_n,
	input wire logic [2:0] cpu_ipl,
	input wire logic nonmaskable_irq,
	input wire logic cpu_avec
);
	logic [2:0] ipi_lvl;
	logic [3:0] hot;
	assign ipi_lvl = jmp_ipi_level7 ? 3'h7 : 3'h4;
	// levels outside 3..6 shift out to zero
	assign hot = 4'h1 << (bp_iack_lvl - 3'h3);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_hit;
		$fell(bp_as_n) && bp_addr == jmp_ipi_addr;
	endsequence
	sequence s_ack;
		!bp_iack_n && !bp_iackin_n && (hot & bp_irq_oe) != 4'h0;
	endsequence
	property p_nmi;
		1'b1 |=> nonmaskable_irq == !$past(power_fail_n && parity_err_n);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi wrong");
	property p_nmi7;
		!power_fail_n |=> cpu_ipl == 3'h7;
	endproperty
	a_nmi7: assert property (p_nmi7) else $error("nmi level");
	property p_ipi;
		s_hit |-> ##[1:2] cpu_ipl >= ipi_lvl;
	endproperty
	a_ipi: assert property (p_ipi) else $error("ipi level");
	property p_avec;
		s_hit ##3 (cpu_iack && cpu_iack_lvl == ipi_lvl) |=> cpu_avec;
	endproperty
	a_avec: assert property (p_avec) else $error("no autovector");
	property p_nvec;
		cpu_avec |-> $past(cpu_iack) && $past(cpu_iack_lvl) != 3'h5;
	endproperty
	a_nvec: assert property (p_nvec) else $error("stray autovector");
	property p_oe;
		bp_irq_oe != 4'h0 |-> $onehot(bp_irq_oe) && bp_irq_out == 4'h0;
	endproperty
	a_oe: assert property (p_oe) else $error("request drive");
	property p_vec;
		s_ack |=> !bp_dtack_n && bp_data_oe;
	endproperty
	a_vec: assert property (p_vec) else $error("no vector");
	// own acknowledge must not travel down the chain
	property p_keep;
		s_ack |=> bp_iackout_n;
	endproperty
	a_keep: assert property (p_keep) else $error("ack passed on");
	property p_rel;
		bp_iack_n && !bp_dtack_n |=>
			bp_irq_oe == 4'h0 && bp_dtack_n && !bp_data_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("not withdrawn");
endmodule : bih_chk
bind bih_top bih_chk u_chk (.*);
`default_nettype wire

/* sim/bih_bp_model.sv */
// backplane peer acknowledging the vectored request
`timescale 1ns/100ps
`default_nettype none
module bih_bp_model (
	// clock, reset and pace
	input wire logic clock,
	input wire logic srst,
	input wire logic slow,
	// from the board
	input wire logic [6:3] bp_irq_oe,
	input wire logic bp_dtack_n,
	input wire logic [7:0] bp_data_out,
	input wire logic bp_data_oe,
	// acknowledge and vector taken
	output logic bp_iack_n,
	output logic bp_iackin_n,
	output logic [2:0] bp_iack_lvl,
	output logic [7:0] vec,
	output logic vec_v
);
	logic [1:0] st;
	logic [2:0] cnt;
	assign bp_iackin_n = bp_iack_n;
	always @(posedge clock)
	begin
		vec_v <= 1'b0;
		if (srst)
		begin
			st <= 2'h0;
			bp_iack_n <= 1'b1;
			bp_iack_lvl <= 3'h0;
		end
		else if (st == 2'h0 && bp_irq_oe != 4'h0)
		begin
			st <= 2'h1;
			cnt <= slow ? 3'h7 : 3'h1;
		end
		else if (st == 2'h1)
		begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1)
			begin
				st <= 2'h2;
				bp_iack_n <= 1'b0;
				bp_iack_lvl <= bp_irq_oe[6] ? 3'h6 : bp_irq_oe[5] ? 3'h5 :
					bp_irq_oe[4] ? 3'h4 : 3'h3;
			end
		end
		else if (st == 2'h2 && !bp_dtack_n)
		begin
			st <= 2'h3;
			vec <= bp_data_oe ? bp_data_out : ~bp_data_out;
			vec_v <= 1'b1;
			bp_iack_n <= 1'b1;
			bp_iack_lvl <= ~bp_iack_lvl;
		end
		else if (st == 2'h3 && bp_irq_oe == 4'h0)
			st <= 2'h0;
	end
endmodule : bih_bp_model
`default_nettype wire

/* sim/test_board_interrupt_handler.sv */
// self-checking bench of the board interrupt handler
`include "bih_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module test_board_interrupt_handler;
	logic clock, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, jmp_ipi_level7;
	logic serial_port_irq_n, power_fail_n, parity_err_n, bp_as_n;
	logic bp_iack_n, bp_iackin_n, bp_iackout_n, bp_data_oe, bp_dtack_n;
	logic nonmaskable_irq, cpu_iack, cpu_avec, irq, slow, vec_v;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [31:0] jmp_ipi_addr, bp_addr, seed;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic [7:1] jmp_level_en, bp_irq_n;
	logic [6:3] bp_irq_out, bp_irq_oe;
	logic [2:0] bp_iack_lvl, cpu_ipl, cpu_iack_lvl;
	logic [7:0] bp_data_out, vec, v;
	logic [33:0] exp_q[$];
	int n_fail, checks_done, cyc;
	bih_top #(.TICK_CYCLES(3000)) dut_u (.*);
	bih_bp_model bp_u (.*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task check(input logic [33:0] seen, input logic [33:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : check
	task final_report;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task axi_wr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clock);
		exp_q.push_back({32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [31:0] a, input logic [33:0] e);
		@(posedge clock);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task lv(input logic [2:0] e);
		repeat (2) @(posedge clock);
		check({31'h0, cpu_ipl}, {31'h0, e});
	endtask : lv
	task ack(input logic [2:0] l, input logic e);
		cpu_iack_lvl <= l;
		cpu_iack <= 1'b1;
		repeat (2) @(posedge clock);
		check({33'h0, cpu_avec}, {33'h0, e});
		cpu_iack <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : ack
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			n_fail++;
			final_report();
		end
	end
	// decode errors carry no data worth comparing
	always @(posedge clock)
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rresp == 2'h3 ? 32'h0 : s_axi_rdata},
				exp_q.pop_front());
		else if (s_axi_bvalid && s_axi_bready)
			check({32'h0, s_axi_bresp}, exp_q.pop_front());
		else if (vec_v)
			check({26'h0, vec}, exp_q.pop_front());
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, cpu_iack, slow} = 4'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, bp_addr} = 128'h0;
		{serial_port_irq_n, power_fail_n, parity_err_n, bp_as_n} = 4'hf;
		{jmp_level_en, bp_irq_n, jmp_ipi_level7} = {7'h0, 7'h7f, 1'b0};
		s_axi_wstrb = 4'hf;
		cpu_iack_lvl = 3'h0;
		seed = 32'hcd26;
		jmp_ipi_addr = xs(seed);
		srst = 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		axi_rd(`BIH_VECTOR_ADDR, {26'h0, `BIH_VECTOR_RST});
		seed = xs(jmp_ipi_addr);
		v = seed[7:0];
		axi_wr(`BIH_VECTOR_ADDR, seed, `BIH_RESP_OKAY);
		axi_rd(`BIH_VECTOR_ADDR, {26'h0, v});
		axi_rd(32'h5c00_0040, {2'h3, 32'h0});
		// unmapped write must leave the vector alone
		axi_wr(32'h5c00_0040, ~seed, `BIH_RESP_DECERR);
		axi_rd(`BIH_VECTOR_ADDR, {26'h0, v});
		axi_wr(`BIH_MASK_ADDR, 32'hf, `BIH_RESP_OKAY);
		axi_rd(`BIH_MASK_ADDR, 34'hf);
		for (int i = 1; i < 8; i++)
		begin
			seed = xs(seed);
			jmp_level_en <= seed[7:1];
			bp_irq_n <= ~(7'h1 << (i - 1));
			lv(seed[i] ? i[2:0] : 3'h0);
		end
		bp_irq_n <= 7'h7f;
		for (int k = 0; k < 2; k++)
		begin
			{power_fail_n, parity_err_n} <= k ? 2'h2 : 2'h1;
			lv(3'h7);
			check({33'h0, nonmaskable_irq}, 34'h1);
		end
		{power_fail_n, parity_err_n} <= 2'h3;
		lv(3'h0);
		check({33'h0, nonmaskable_irq}, 34'h0);
		check({33'h0, irq}, 34'h1);
		axi_rd(`BIH_STATUS_ADDR, 34'h1);
		repeat (2) @(posedge clock);
		check({33'h0, irq}, 34'h0);
		serial_port_irq_n <= 1'b0;
		lv(3'h5);
		ack(3'h5, 1'b0);
		serial_port_irq_n <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			jmp_ipi_level7 <= k[0];
			@(posedge clock);
			bp_addr <= jmp_ipi_addr;
			bp_as_n <= 1'b0;
			@(posedge clock);
			bp_as_n <= 1'b1;
			bp_addr <= ~jmp_ipi_addr;
			lv(k ? 3'h7 : 3'h4);
			ack(k ? 3'h7 : 3'h4, 1'b1);
			lv(3'h0);
		end
		while (cpu_ipl !== 3'h6)
			@(posedge clock);
		axi_rd(`BIH_STATUS_ADDR, 34'h6);
		ack(3'h6, 1'b1);
		lv(3'h0);
		for (int l = 2; l < 7; l++)
		begin
			slow <= l[0];
			axi_wr(`BIH_CTRL_ADDR, 32'h100 | l, `BIH_RESP_OKAY);
			check({30'h0, bp_irq_oe}, 34'(l > 2) << (l - 3));
			// slow peer leaves time to see the pending state
			if (l[0])
				axi_rd(`BIH_STATE_ADDR, {26'h0, 4'(1 << (l - 3)), 4'h1});
			if (l > 2)
				exp_q.push_back({26'h0, v});
			for (int w = 0; w < 40 && bp_irq_oe !== 4'h0; w++)
				@(posedge clock);
			check({30'h0, bp_irq_oe}, 34'h0);
		end
		axi_rd(`BIH_STATUS_ADDR, 34'h8);
		final_report();
	end
endmodule : test_board_interrupt_handler
`default_nettype wire
